//--- logic/farith_decode.sv
// top of the flag-transfer / carry-arithmetic / add-adjust decoder:
// takes opcode bytes, fetches a modrm byte when needed, sequences clocks.
// assumes the byte source holds each byte until byteTaken.
`timescale 1ns/100ps
`default_nettype none
module farith_decode
    import farith_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // byte stream in
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    output logic byteTaken,
    // decoded instruction
    output farith_op_t opOut,
    output farith_form_t formOut,
    output logic wideOut,
    output logic dirOut,
    output logic signOut,
    output logic [2:0] regOut,
    output logic [2:0] rmOut,
    output logic [1:0] modOut,
    output logic [3:0] clocksOut,
    // status
    output logic busy,
    output logic done,
    output logic unknownOp
);
    // ==============================
    // state
    typedef enum logic [1:0] {S_OPCODE, S_MODRM, S_EXEC} farith_state_t;
    farith_state_t state_reg;
    logic [7:0] op_reg;
    logic [3:0] count_reg;
    farith_dec_if dec ();

    farith_classify u_classify (
        .dec(dec)
    );

    // opcode byte is read from the bus in S_OPCODE, and from op_reg once it has been captured
    assign dec.opByte = (state_reg == S_OPCODE) ? byteData : op_reg;
    assign dec.modrmByte = byteData;

    // ==============================
    // take decisions from the same-clock byte source; execLast comes from state and countdown only
    logic accept;
    logic takeOpcode;
    logic takeModrm;
    logic opcodeNeedsModrm;
    logic opcodeUnknown;
    logic opcodeStarts;
    logic modrmUnknown;
    logic modrmStarts;
    logic execStart;
    logic execLast;

    // the consume pulse doubles as a one-cycle hold-off, so a source slow to
    // drop byteValid cannot have the same byte taken twice
    assign accept = byteValid && !byteTaken && (state_reg != S_EXEC);
    assign takeOpcode = accept && (state_reg == S_OPCODE);
    assign takeModrm = accept && (state_reg == S_MODRM);
    assign opcodeNeedsModrm = takeOpcode && dec.needsModrm;
    assign opcodeUnknown = takeOpcode && !dec.needsModrm && (dec.op == FA_NONE);
    assign opcodeStarts = takeOpcode && !dec.needsModrm && (dec.op != FA_NONE);
    assign modrmUnknown = takeModrm && (dec.op == FA_NONE);
    assign modrmStarts = takeModrm && (dec.op != FA_NONE);
    assign execStart = opcodeStarts || modrmStarts;
    // a count of 1 still spends one execute cycle, nothing ends on its take edge
    assign execLast = (state_reg == S_EXEC) && (count_reg <= 4'h1);

    // ==============================
    // sequencer state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= S_OPCODE;
        end else begin
            unique case (state_reg)
                S_OPCODE: begin
                    if (opcodeNeedsModrm) begin
                        state_reg <= S_MODRM;
                    end else if (opcodeStarts) begin
                        state_reg <= S_EXEC;
                    end
                end
                S_MODRM: begin
                    if (modrmUnknown) begin
                        state_reg <= S_OPCODE;
                    end else if (modrmStarts) begin
                        state_reg <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    if (execLast) begin
                        state_reg <= S_OPCODE;
                    end
                end
            endcase
        end
    end

    // ==============================
    // execute countdown, loaded with one less than the count of the decoded form
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= CLK_RESET;
        end else if (execStart) begin
            count_reg <= dec.clocks - 4'h1;
        end else if ((state_reg == S_EXEC) && !execLast) begin
            count_reg <= count_reg - 4'h1;
        end
    end

    // ==============================
    // opcode held for the classifier while the modrm byte is on the bus
    always_ff @(posedge clock) begin
        if (rst) begin
            op_reg <= 8'h00;
        end else if (takeOpcode) begin
            op_reg <= byteData;
        end
    end

    // ==============================
    // consume pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            byteTaken <= 1'b0;
        end else begin
            byteTaken <= accept;
        end
    end

    // ==============================
    // busy from the first byte of an instruction to its done pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (opcodeNeedsModrm || opcodeStarts) begin
            busy <= 1'b1;
        end else if (modrmUnknown || execLast) begin
            busy <= 1'b0;
        end
    end

    // ==============================
    // done pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= execLast;
        end
    end

    // ==============================
    // unknown pulse: foreign opcode, or group opcode with a foreign reg field
    always_ff @(posedge clock) begin
        if (rst) begin
            unknownOp <= 1'b0;
        end else begin
            unknownOp <= opcodeUnknown || modrmUnknown;
        end
    end

    // ==============================
    // decoded class, latched when the last byte of the instruction is taken
    always_ff @(posedge clock) begin
        if (rst) begin
            opOut <= FA_NONE;
            formOut <= FORM_NONE;
        end else if (execStart) begin
            opOut <= dec.op;
            formOut <= dec.form;
        end
    end

    // ==============================
    // width, direction and sign-extension bits; d and s mean something only
    // in the forms that carry them, so they read 0 elsewhere
    always_ff @(posedge clock) begin
        if (rst) begin
            wideOut <= 1'b0;
            dirOut <= 1'b0;
            signOut <= 1'b0;
        end else if (execStart) begin
            wideOut <= dec.wideBit;
            dirOut <= (dec.form == FORM_RM) ? dec.dirBit : 1'b0;
            signOut <= (dec.form == FORM_IMM) ? dec.signBit : 1'b0;
        end
    end

    // ==============================
    // operand byte fields, 0 for the forms that have no operand byte
    always_ff @(posedge clock) begin
        if (rst) begin
            regOut <= 3'h0;
            rmOut <= 3'h0;
            modOut <= 2'h0;
        end else if (modrmStarts) begin
            regOut <= byteData[REG_HI:REG_LO];
            rmOut <= byteData[RM_HI:RM_LO];
            modOut <= byteData[MOD_HI:MOD_LO];
        end else if (opcodeStarts) begin
            regOut <= 3'h0;
            rmOut <= 3'h0;
            modOut <= 2'h0;
        end
    end

    // ==============================
    // clock count of the instruction
    always_ff @(posedge clock) begin
        if (rst) begin
            clocksOut <= CLK_RESET;
        end else if (execStart) begin
            clocksOut <= dec.clocks;
        end
    end
endmodule // farith_decode
`default_nettype wire

//--- logic/farith_pkg.sv
// package of opcode patterns, field positions and clock counts for the
// flag-transfer / carry-arithmetic / add-adjust decoder.
// assumes nothing beyond a SystemVerilog compiler.
package farith_pkg;
    // ==============================
    // opcode patterns
    localparam logic [7:0] OP_LOAD_HIGH_ACC = 8'h9F;
    localparam logic [7:0] OP_STORE_HIGH_ACC = 8'h9E;
    localparam logic [7:0] OP_ASCII_ADJ = 8'h37;
    localparam logic [7:0] OP_DECIMAL_ADJ = 8'h27;
    localparam logic [5:0] OP_ADC_RM = 6'h04;     // 000100dw
    localparam logic [6:0] OP_ADC_ACC = 7'h0A;    // 0001010w
    localparam logic [5:0] OP_BORROW_RM = 6'h06;     // 000110dw
    localparam logic [6:0] OP_BORROW_ACC = 7'h0E;    // 0001110w
    localparam logic [5:0] OP_IMM_GROUP = 6'h20;  // 100000sw
    localparam logic [2:0] GRP_ADC = 3'h2;
    localparam logic [2:0] GRP_BORROW = 3'h3;
    localparam logic [1:0] MOD_REG = 2'h3;
    // ==============================
    // field positions in the operand byte
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int REG_HI = 5;
    localparam int REG_LO = 3;
    localparam int RM_HI = 2;
    localparam int RM_LO = 0;
    // ==============================
    // clock counts, same in real and protected mode
    localparam logic [3:0] CLK_FLAG_XFER = 4'h2;
    localparam logic [3:0] CLK_RM_REG = 4'h2;
    localparam logic [3:0] CLK_IMM_REG = 4'h3;
    localparam logic [3:0] CLK_MEM = 4'h7;
    localparam logic [3:0] CLK_ACC_IMM = 4'h3;
    localparam logic [3:0] CLK_ADJUST = 4'h3;
    localparam logic [3:0] CLK_RESET = 4'h0;
    // ==============================
    // operation classes
    typedef enum logic [2:0] {
        FA_NONE, FA_LOAD_HIGH_ACC, FA_STORE_HIGH_ACC, FA_ADC,
        FA_SUBTRACT_WITH_BORROW, FA_ASCII_ADD_ADJUST, FA_DECIMAL_ADD_ADJUST
    } farith_op_t;
    typedef enum logic [1:0] {FORM_NONE, FORM_RM, FORM_IMM, FORM_ACC} farith_form_t;
endpackage

//--- logic/farith_dec_if.sv
// carrier between the sequencer and its combinational opcode classifier.
// assumes both ends share one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface farith_dec_if;
    import farith_pkg::*;
    logic [7:0] opByte;
    logic [7:0] modrmByte;
    farith_op_t op;
    farith_form_t form;
    logic needsModrm;
    logic wideBit;
    logic dirBit;
    logic signBit;
    logic [3:0] clocks;
    modport classifier (input opByte, modrmByte,
        output op, form, needsModrm, wideBit, dirBit, signBit, clocks);
    modport user (output opByte, modrmByte,
        input op, form, needsModrm, wideBit, dirBit, signBit, clocks);
endinterface
`default_nettype wire

//--- logic/farith_classify.sv
// combinational opcode classifier: op class, form, d/w/s bits, clock count.
// assumes the operand byte is valid only when needsModrm is set.
`timescale 1ns/100ps
`default_nettype none
module farith_classify
    import farith_pkg::*;
(
    farith_dec_if.classifier dec
);
    logic isMem;
    logic [7:0] b;
    logic [2:0] grp;
    always_comb begin
        b = dec.opByte;
        grp = dec.modrmByte[REG_HI:REG_LO];
        isMem = (dec.modrmByte[MOD_HI:MOD_LO] != MOD_REG);
        dec.op = FA_NONE;
        dec.form = FORM_NONE;
        dec.needsModrm = 1'b0;
        dec.clocks = CLK_RESET;
        dec.wideBit = b[0];
        dec.dirBit = b[1];
        dec.signBit = b[1];
        if (b == OP_LOAD_HIGH_ACC) begin
            dec.op = FA_LOAD_HIGH_ACC;
            dec.clocks = CLK_FLAG_XFER;
        end else if (b == OP_STORE_HIGH_ACC) begin
            dec.op = FA_STORE_HIGH_ACC;
            dec.clocks = CLK_FLAG_XFER;
        end else if (b == OP_ASCII_ADJ) begin
            dec.op = FA_ASCII_ADD_ADJUST;
            dec.clocks = CLK_ADJUST;
        end else if (b == OP_DECIMAL_ADJ) begin
            dec.op = FA_DECIMAL_ADD_ADJUST;
            dec.clocks = CLK_ADJUST;
        end else if (b[7:2] == OP_ADC_RM || b[7:2] == OP_BORROW_RM) begin
            dec.op = (b[7:2] == OP_ADC_RM) ? FA_ADC : FA_SUBTRACT_WITH_BORROW;
            dec.form = FORM_RM;
            dec.needsModrm = 1'b1;
            dec.clocks = isMem ? CLK_MEM : CLK_RM_REG;
        end else if (b[7:2] == OP_IMM_GROUP && (grp == GRP_ADC || grp == GRP_BORROW)) begin
            dec.op = (grp == GRP_ADC) ? FA_ADC : FA_SUBTRACT_WITH_BORROW;
            dec.form = FORM_IMM;
            dec.needsModrm = 1'b1;
            dec.clocks = isMem ? CLK_MEM : CLK_IMM_REG;
        end else if (b[7:1] == OP_ADC_ACC || b[7:1] == OP_BORROW_ACC) begin
            dec.op = (b[7:1] == OP_ADC_ACC) ? FA_ADC : FA_SUBTRACT_WITH_BORROW;
            dec.form = FORM_ACC;
            dec.clocks = CLK_ACC_IMM;
        end
        // the group opcode with another reg field belongs to other decoders
        if (b[7:2] == OP_IMM_GROUP && grp != GRP_ADC && grp != GRP_BORROW) begin
            dec.needsModrm = 1'b1;
        end
    end
endmodule // farith_classify
`default_nettype wire

//--- bench/farith_decode_chk.sv
// checker for the opcode decoder top: decode classes and execute timing.
// assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module farith_decode_chk
    import farith_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // observed outputs
    input wire logic byteTaken,
    input var farith_op_t opOut,
    input var farith_form_t formOut,
    input wire logic [2:0] regOut,
    input wire logic [1:0] modOut,
    input wire logic [3:0] clocksOut,
    input wire logic busy,
    input wire logic done
);
    logic [3:0] sinceTake_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    function automatic logic [3:0] carryClk(farith_form_t f, logic [1:0] m);
        if (f == FORM_ACC) return 4'h3;
        if (m != 2'h3) return 4'h7;
        return (f == FORM_IMM) ? 4'h3 : 4'h2;
    endfunction
    // ==============================
    // cycles since the last byte was consumed, saturating
    always_ff @(posedge clock) begin
        if (rst) begin
            sinceTake_reg <= 4'h0;
        end else if (byteTaken) begin
            sinceTake_reg <= 4'h1;
        end else if (sinceTake_reg != 4'hF) begin
            sinceTake_reg <= sinceTake_reg + 4'h1;
        end
    end
    // ==============================
    // properties
    a_load_flags: assert property (
        done && opOut == FA_LOAD_HIGH_ACC |-> clocksOut == 4'h2)
        else $error("flag copy clock count wrong");
    a_store_flags: assert property (
        done && opOut == FA_STORE_HIGH_ACC |-> clocksOut == 4'h2)
        else $error("flag load clock count wrong");
    a_adc_clocks: assert property (
        done && opOut == FA_ADC |-> clocksOut == carryClk(formOut, modOut))
        else $error("add with carry clock count wrong");
    a_borrow_clocks: assert property (
        done && opOut == FA_SUBTRACT_WITH_BORROW |-> clocksOut == carryClk(formOut, modOut))
        else $error("subtract with borrow clock count wrong");
    a_ascii_clocks: assert property (
        done && opOut == FA_ASCII_ADD_ADJUST |-> clocksOut == 4'h3)
        else $error("ascii adjust clock count wrong");
    a_decimal_clocks: assert property (
        done && opOut == FA_DECIMAL_ADD_ADJUST |-> clocksOut == 4'h3)
        else $error("decimal adjust clock count wrong");
    a_done_spacing: assert property (
        done |-> sinceTake_reg == clocksOut - 4'h1)
        else $error("done not at clock count");
    a_group_reg: assert property (
        done && formOut == FORM_IMM |-> regOut == (opOut == FA_ADC ? 3'h2 : 3'h3))
        else $error("immediate group reg field mismatch");
    a_busy_end: assert property (
        done |-> !busy && $past(busy))
        else $error("busy not ending at done");
endmodule // farith_decode_chk
bind farith_decode farith_decode_chk u_farith_decode_chk(.clock(clock), .rst(rst),
    .byteTaken(byteTaken), .opOut(opOut), .formOut(formOut), .regOut(regOut),
    .modOut(modOut), .clocksOut(clocksOut), .busy(busy), .done(done));
`default_nettype wire

//--- bench/test_flag_arith_opcode_decode.sv
// bench for the opcode decoder: offers bytes, checks decode and timing.
// assumes the checker file is compiled with it and binds itself.
`timescale 1ns/100ps
`default_nettype none
module test_flag_arith_opcode_decode;
    import farith_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic byteValid = 1'b0;
    logic [7:0] byteData = 8'h00;
    logic byteTaken, wideOut, dirOut, signOut, busy, done, unknownOp;
    farith_op_t opOut;
    farith_form_t formOut;
    logic [2:0] regOut, rmOut;
    logic [1:0] modOut;
    logic [3:0] clocksOut;
    int errors = 0;
    int checked = 0;
    always #4 clock = ~clock;
    farith_decode u_farith_decode(.clock(clock), .rst(rst), .byteValid(byteValid),
        .byteData(byteData), .byteTaken(byteTaken), .opOut(opOut), .formOut(formOut),
        .wideOut(wideOut), .dirOut(dirOut), .signOut(signOut), .regOut(regOut),
        .rmOut(rmOut), .modOut(modOut), .clocksOut(clocksOut), .busy(busy),
        .done(done), .unknownOp(unknownOp));
    // ==============================
    // shared tasks
    task automatic end_sim();
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // holds the byte until the consume pulse shows
    task automatic send(input logic [7:0] b);
        int i;
        i = 0;
        byteValid = 1'b1;
        byteData = b;
        do begin
            @(posedge clock);
            #1;
            i++;
        end while (byteTaken !== 1'b1 && i < 20);
        byteValid = 1'b0;
        byteData = ~b;
        if (byteTaken !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic two,
            input farith_op_t eOp, input farith_form_t eForm, input logic [3:0] eClk);
        logic [19:0] exp;
        int k;
        send(b0);
        if (two) begin
            @(posedge clock);
            #1;
            send(b1);
        end
        chk("unknown", {19'h0, unknownOp}, {19'h0, eOp == FA_NONE});
        chk("busy", {19'h0, busy}, {19'h0, eOp != FA_NONE});
        if (eOp != FA_NONE) begin
            exp = {eOp, eForm, b0[0], b0[1] & (eForm == FORM_RM),
                b0[1] & (eForm == FORM_IMM), two ? b1 : 8'h00, eClk};
            chk("decode", {opOut, formOut, wideOut, dirOut, signOut, modOut, regOut,
                rmOut, clocksOut}, exp);
            k = 0;
            do begin
                @(posedge clock);
                #1;
                k++;
            end while (done !== 1'b1 && k < 20);
            if (done !== 1'b1) begin
                errors++;
                end_sim();
            end
            chk("done gap", 20'(k), {16'h0, eClk - 4'h1});
            chk("busy at done", {19'h0, busy}, 20'h0);
        end else begin
            @(posedge clock);
            #1;
        end
    endtask
    // ==============================
    // scenarios
    task automatic t_flags();
        run(8'h9F, 8'h00, 1'b0, FA_LOAD_HIGH_ACC, FORM_NONE, 4'h2);
        run(8'h9E, 8'h00, 1'b0, FA_STORE_HIGH_ACC, FORM_NONE, 4'h2);
    endtask
    task automatic t_adc();
        run(8'h10, 8'hC1, 1'b1, FA_ADC, FORM_RM, 4'h2);
        run(8'h13, 8'h46, 1'b1, FA_ADC, FORM_RM, 4'h7);
        run(8'h83, 8'hD0, 1'b1, FA_ADC, FORM_IMM, 4'h3);
        run(8'h80, 8'h16, 1'b1, FA_ADC, FORM_IMM, 4'h7);
        run(8'h15, 8'h00, 1'b0, FA_ADC, FORM_ACC, 4'h3);
    endtask
    task automatic t_borrow();
        run(8'h1A, 8'hC1, 1'b1, FA_SUBTRACT_WITH_BORROW, FORM_RM, 4'h2);
        run(8'h1B, 8'h86, 1'b1, FA_SUBTRACT_WITH_BORROW, FORM_RM, 4'h7);
        run(8'h81, 8'hD8, 1'b1, FA_SUBTRACT_WITH_BORROW, FORM_IMM, 4'h3);
        run(8'h83, 8'h5E, 1'b1, FA_SUBTRACT_WITH_BORROW, FORM_IMM, 4'h7);
        run(8'h1C, 8'h00, 1'b0, FA_SUBTRACT_WITH_BORROW, FORM_ACC, 4'h3);
    endtask
    task automatic t_adjust();
        run(8'h37, 8'h00, 1'b0, FA_ASCII_ADD_ADJUST, FORM_NONE, 4'h3);
        run(8'h27, 8'h00, 1'b0, FA_DECIMAL_ADD_ADJUST, FORM_NONE, 4'h3);
    endtask
    // group opcode with a foreign reg field, and a plain add opcode
    task automatic t_foreign();
        run(8'h83, 8'hC0, 1'b1, FA_NONE, FORM_NONE, 4'h0);
        run(8'h83, 8'hF8, 1'b1, FA_NONE, FORM_NONE, 4'h0);
        run(8'h00, 8'h00, 1'b0, FA_NONE, FORM_NONE, 4'h0);
    endtask
    // a byte offered while an adjust executes waits until execution ends
    task automatic t_refuse();
        int n;
        send(8'h37);
        @(posedge clock);
        #1;
        byteValid = 1'b1;
        byteData = 8'h9F;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (byteTaken !== 1'b1 && n < 20);
        byteValid = 1'b0;
        if (byteTaken !== 1'b1) begin
            errors++;
            end_sim();
        end
        chk("held off", 20'(n), {16'h0, CLK_ADJUST - 4'h1});
        repeat (2) @(posedge clock);
        #1;
        chk("after hold", {17'h0, opOut}, {17'h0, FA_LOAD_HIGH_ACC});
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        chk("reset", {opOut, formOut, clocksOut, busy, done}, 20'h0);
        t_flags();
        t_adc();
        t_borrow();
        t_adjust();
        t_foreign();
        t_refuse();
        t_flags();
        end_sim();
    end
endmodule // test_flag_arith_opcode_decode
`default_nettype wire
